// ===== inc/cfg_pin_pkg.sv
// Package for the configuration status pin logic.
// Assumes a single 25 MHz clock and a synchronous active-high reset.
package cfg_pin_pkg;
    // Clock period in nanoseconds.
    localparam int CLK_PERIOD_NS = 40;
    // Master-mode extra wait after the initialisation line rises, in microseconds.
    localparam int MASTER_WAIT_MIN_US = 30;
    localparam int MASTER_WAIT_MAX_US = 300;
    // Least wait rounds up to whole cycles.
    localparam int MASTER_WAIT_CYCLES =
        (MASTER_WAIT_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest wait rounds down.
    localparam int MASTER_WAIT_MAX_CYCLES = (MASTER_WAIT_MAX_US * 1000) / CLK_PERIOD_NS;
    // Cycles spent clearing the configuration memory after power is stable.
    localparam int CLEAR_CYCLES = 16;
    // Number of fast clock inputs and global buffer pairs.
    localparam int FAST_CLOCKS = 4;
    localparam int GLOBAL_PAIRS = 8;
    localparam int SECONDARY_INPUTS = 4;
    // Counter width for the sequencing counter.
    localparam int CNT_W = 16;
    // Reset values of the pin drivers.
    localparam logic BUSY_HIGH_RESET = 1'b1;
    localparam logic BUSY_LOW_RESET = 1'b0;

    // Configuration sequence states, Gray coded along the master-mode path.
    typedef enum logic [2:0] {
        ST_POWER = 3'b000,
        ST_CLEAR = 3'b001,
        ST_WAIT = 3'b011,
        ST_MWAIT = 3'b010,
        ST_LOAD = 3'b110,
        ST_ERROR = 3'b111,
        ST_USER = 3'b100
    } cfg_state_e;
endpackage

// ===== rtl/pin_sync.sv
// Two-flip-flop synchroniser bank for pins arriving from outside the clock domain.
// Assumes ref_clk is the only clock; the first stage feeds only the second.
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    // Next values hold while the clock enable is low.
    always_comb begin
        meta_next = clk_en ? async_in : meta_reg;
        sync_next = clk_en ? meta_reg : sync_reg;
    end

    // Registers both stages; reset loads all ones, the idle level of pulled-up pins.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_reg <= '1;
            sync_reg <= '1;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule

// ===== rtl/config_status_pin_logic.sv
// Configuration status pin sequencer with test access and clock input routing.
// Assumes one 25 MHz clock, synchronous reset, and pad-level wires built outside.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Busy-high pin driven high until user I/O active, then released.
// - Busy-low pin driven low until user I/O active, then released.
// - Init line pulled low during power settling and memory clearing.
// - Externally held-low init line keeps device waiting before configuration.
// - Master mode waits an extra 30 to 300 us after init rises.
// - Configuration data error drives init line low during configuration.
// - After user I/O active, init line becomes general-purpose I/O.
// - Without boundary-scan macro, scan disabled after user I/O active and test pins become user I/O.
// - Test pins pass through the pin synchronisers and a register; feed user logic afterwards.
// - Each low-skew and early buffer pair takes one shared input.
// - Four fast I/O clocks serve left/right upper/lower octants.
module config_status_pin_logic #(
    parameter int WAIT_CYCLES = cfg_pin_pkg::MASTER_WAIT_CYCLES,
    parameter int CLR_CYCLES = cfg_pin_pkg::CLEAR_CYCLES,
    parameter int NPAIR = cfg_pin_pkg::GLOBAL_PAIRS,
    parameter int NFAST = cfg_pin_pkg::FAST_CLOCKS,
    parameter int NSEC = cfg_pin_pkg::SECONDARY_INPUTS
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic power_stable,
    input wire logic master_mode,
    input wire logic load_done,
    input wire logic data_error,
    input wire logic boundary_scan_macro,
    input wire logic init_in,
    output logic init_out,
    output logic init_oe,
    output logic config_busy_high_out,
    output logic config_busy_high_oe,
    output logic config_busy_low_out,
    output logic config_busy_low_oe,
    output logic config_start,
    output logic user_io_active,
    input wire logic user_init_out,
    input wire logic user_init_oe,
    input wire logic user_busy_high_out,
    input wire logic user_busy_high_oe,
    input wire logic user_busy_low_out,
    input wire logic user_busy_low_oe,
    input wire logic [2:0] test_pads_in,
    output logic [2:0] test_to_scan,
    output logic [2:0] test_to_user,
    output logic scan_enable,
    input wire logic [NPAIR-1:0] global_clock_inputs,
    input wire logic [NPAIR-1:0] global_from_logic,
    input wire logic [NPAIR-1:0] global_sel_logic,
    input wire logic [NPAIR-1:0] global_pin_used,
    output logic [NPAIR-1:0] low_skew_clock_buffer,
    output logic [NPAIR-1:0] early_clock_buffer,
    output logic [NPAIR-1:0] global_user_io,
    input wire logic [NSEC-1:0] secondary_global_inputs,
    input wire logic [NSEC-1:0] secondary_from_logic,
    input wire logic [NSEC-1:0] secondary_sel_logic,
    input wire logic [NSEC-1:0] secondary_pin_used,
    output logic [NSEC-1:0] secondary_global_net,
    output logic [NSEC-1:0] secondary_user_io,
    input wire logic [NFAST-1:0] fast_io_clock_inputs,
    output logic [NFAST-1:0] fast_octant_clock
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    localparam int NSYNC = 4 + NPAIR + NSEC + NFAST;
    logic [NSYNC-1:0] sync_in;
    logic [NSYNC-1:0] sync_q;
    logic init_s;
    logic [2:0] test_s;
    logic [NPAIR-1:0] gck_s;
    logic [NSEC-1:0] sec_s;
    logic [NFAST-1:0] fast_s;

    assign sync_in = {fast_io_clock_inputs, secondary_global_inputs, global_clock_inputs,
                      test_pads_in, init_in};
    assign init_s = sync_q[0];
    assign test_s = sync_q[3:1];
    assign gck_s = sync_q[3+NPAIR:4];
    assign sec_s = sync_q[3+NPAIR+NSEC:4+NPAIR];
    assign fast_s = sync_q[NSYNC-1:4+NPAIR+NSEC];

    pin_sync #(.WIDTH(NSYNC)) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .async_in(sync_in),
        .sync_out(sync_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Configuration sequencer.
    cfg_pin_pkg::cfg_state_e state_reg;
    cfg_pin_pkg::cfg_state_e state_next;
    logic [cfg_pin_pkg::CNT_W-1:0] cnt_reg;
    logic [cfg_pin_pkg::CNT_W-1:0] cnt_next;
    logic start_reg;
    logic start_next;

    // Computes the next sequencer state and the wait counter.
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        start_next = 1'b0;
        case (state_reg)
            cfg_pin_pkg::ST_POWER: begin
                cnt_next = '0;
                if (power_stable) begin
                    state_next = cfg_pin_pkg::ST_CLEAR;
                end
            end
            cfg_pin_pkg::ST_CLEAR: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == cfg_pin_pkg::CNT_W'(CLR_CYCLES - 1)) begin
                    state_next = cfg_pin_pkg::ST_WAIT;
                    cnt_next = '0;
                end
            end
            cfg_pin_pkg::ST_WAIT: begin
                cnt_next = '0;
                if (init_s) begin
                    if (master_mode) begin
                        state_next = cfg_pin_pkg::ST_MWAIT;
                    end else begin
                        state_next = cfg_pin_pkg::ST_LOAD;
                        start_next = 1'b1;
                    end
                end
            end
            cfg_pin_pkg::ST_MWAIT: begin
                cnt_next = cnt_reg + 1'b1;
                if (!init_s) begin
                    state_next = cfg_pin_pkg::ST_WAIT;
                    cnt_next = '0;
                end else if (cnt_reg == cfg_pin_pkg::CNT_W'(WAIT_CYCLES - 1)) begin
                    state_next = cfg_pin_pkg::ST_LOAD;
                    start_next = 1'b1;
                end
            end
            cfg_pin_pkg::ST_LOAD: begin
                if (data_error) begin
                    state_next = cfg_pin_pkg::ST_ERROR;
                end else if (load_done) begin
                    state_next = cfg_pin_pkg::ST_USER;
                end
            end
            cfg_pin_pkg::ST_ERROR: begin
                state_next = cfg_pin_pkg::ST_ERROR;
            end
            cfg_pin_pkg::ST_USER: begin
                state_next = cfg_pin_pkg::ST_USER;
            end
            default: begin
                state_next = cfg_pin_pkg::ST_POWER;
                cnt_next = '0;
            end
        endcase
    end

    // Registers the sequencer state.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= cfg_pin_pkg::ST_POWER;
            cnt_reg <= '0;
            start_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            start_reg <= start_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status pin drivers.
    logic user_next;
    logic init_out_next;
    logic init_oe_next;
    logic hdc_out_next;
    logic hdc_oe_next;
    logic ldc_out_next;
    logic ldc_oe_next;
    logic scan_en_next;
    logic [2:0] test_scan_next;
    logic [2:0] test_user_next;

    // Drives the status pins during configuration and hands them to user logic afterwards.
    always_comb begin
        user_next = (state_next == cfg_pin_pkg::ST_USER);
        init_out_next = 1'b0;
        init_oe_next = (state_next == cfg_pin_pkg::ST_POWER)
                    || (state_next == cfg_pin_pkg::ST_CLEAR)
                    || (state_next == cfg_pin_pkg::ST_ERROR);
        hdc_out_next = cfg_pin_pkg::BUSY_HIGH_RESET;
        hdc_oe_next = 1'b1;
        ldc_out_next = cfg_pin_pkg::BUSY_LOW_RESET;
        ldc_oe_next = 1'b1;
        if (user_next) begin
            init_out_next = user_init_out;
            init_oe_next = user_init_oe;
            hdc_out_next = user_busy_high_out;
            hdc_oe_next = user_busy_high_oe;
            ldc_out_next = user_busy_low_out;
            ldc_oe_next = user_busy_low_oe;
        end
        scan_en_next = !user_next || boundary_scan_macro;
        test_scan_next = scan_en_next ? test_s : 3'b000;
        test_user_next = user_next ? test_s : 3'b000;
    end

    // Registers the pin drivers so every output comes from a flip-flop.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            user_io_active <= 1'b0;
            config_start <= 1'b0;
            init_out <= 1'b0;
            init_oe <= 1'b1;
            config_busy_high_out <= cfg_pin_pkg::BUSY_HIGH_RESET;
            config_busy_high_oe <= 1'b1;
            config_busy_low_out <= cfg_pin_pkg::BUSY_LOW_RESET;
            config_busy_low_oe <= 1'b1;
            scan_enable <= 1'b1;
            test_to_scan <= 3'b000;
            test_to_user <= 3'b000;
        end else if (clk_en) begin
            user_io_active <= user_next;
            config_start <= start_next;
            init_out <= init_out_next;
            init_oe <= init_oe_next;
            config_busy_high_out <= hdc_out_next;
            config_busy_high_oe <= hdc_oe_next;
            config_busy_low_out <= ldc_out_next;
            config_busy_low_oe <= ldc_oe_next;
            scan_enable <= scan_en_next;
            test_to_scan <= test_scan_next;
            test_to_user <= test_user_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock input routing, one generate loop per resource kind.
    genvar gi;
    generate
        for (gi = 0; gi < NPAIR; gi++) begin : g_pair
            logic src_next;
            // One shared source feeds both buffers of the pair.
            always_comb begin
                src_next = global_sel_logic[gi] ? global_from_logic[gi] : gck_s[gi];
            end
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    low_skew_clock_buffer[gi] <= 1'b0;
                    early_clock_buffer[gi] <= 1'b0;
                    global_user_io[gi] <= 1'b0;
                end else if (clk_en) begin
                    low_skew_clock_buffer[gi] <= src_next;
                    early_clock_buffer[gi] <= src_next;
                    global_user_io[gi] <= global_pin_used[gi] ? 1'b0 : gck_s[gi];
                end
            end
        end
        for (gi = 0; gi < NSEC; gi++) begin : g_sec
            logic net_next;
            // Global net takes logic or pin; an unused pin passes to user I/O.
            always_comb begin
                net_next = secondary_sel_logic[gi] ? secondary_from_logic[gi]
                                                   : (secondary_pin_used[gi] & sec_s[gi]);
            end
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    secondary_global_net[gi] <= 1'b0;
                    secondary_user_io[gi] <= 1'b0;
                end else if (clk_en) begin
                    secondary_global_net[gi] <= net_next;
                    secondary_user_io[gi] <= secondary_pin_used[gi] ? 1'b0 : sec_s[gi];
                end
            end
        end
        for (gi = 0; gi < NFAST; gi++) begin : g_fast
            // Index 0 left upper, 1 left lower, 2 right upper, 3 right lower octant.
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    fast_octant_clock[gi] <= 1'b0;
                end else if (clk_en) begin
                    fast_octant_clock[gi] <= fast_s[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.
    property p_busy_high;
        @(posedge ref_clk) disable iff (rst)
        !user_io_active |-> (config_busy_high_oe && config_busy_high_out);
    endproperty
    a_busy_high: assert property (p_busy_high) else $error("busy high not driven");

    property p_busy_low;
        @(posedge ref_clk) disable iff (rst)
        !user_io_active |-> (config_busy_low_oe && !config_busy_low_out);
    endproperty
    a_busy_low: assert property (p_busy_low) else $error("busy low not driven");

    property p_init_clear;
        @(posedge ref_clk) disable iff (rst)
        (state_reg == cfg_pin_pkg::ST_CLEAR) |-> (init_oe && !init_out);
    endproperty
    a_init_clear: assert property (p_init_clear) else $error("init not low in clear");

    property p_wait_hold;
        @(posedge ref_clk) disable iff (rst || !clk_en)
        (state_reg == cfg_pin_pkg::ST_WAIT && !init_s) |=> !config_start;
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("started while held");

    property p_master_wait;
        @(posedge ref_clk) disable iff (rst)
        (state_reg == cfg_pin_pkg::ST_MWAIT && state_next == cfg_pin_pkg::ST_LOAD)
            |-> (cnt_reg == cfg_pin_pkg::CNT_W'(WAIT_CYCLES - 1));
    endproperty
    a_master_wait: assert property (p_master_wait) else $error("master wait length");

    property p_error_init;
        @(posedge ref_clk) disable iff (rst || !clk_en)
        (state_reg == cfg_pin_pkg::ST_LOAD && data_error) |=> (init_oe && !init_out);
    endproperty
    a_error_init: assert property (p_error_init) else $error("error not reported");

    property p_init_user;
        @(posedge ref_clk) disable iff (rst || !clk_en)
        (state_next == cfg_pin_pkg::ST_USER) |=> (init_oe == $past(user_init_oe));
    endproperty
    a_init_user: assert property (p_init_user) else $error("init not released");

    property p_scan_off;
        @(posedge ref_clk) disable iff (rst)
        (user_io_active && !$past(boundary_scan_macro)) |-> !scan_enable;
    endproperty
    a_scan_off: assert property (p_scan_off) else $error("scan still enabled");

    property p_pair_same;
        @(posedge ref_clk) disable iff (rst)
        low_skew_clock_buffer == early_clock_buffer;
    endproperty
    a_pair_same: assert property (p_pair_same) else $error("pair inputs differ");
endmodule

// ===== dv/sys_ctrl_model.sv
// Model of the system controller that watches and may hold the init line.
// Assumes the bench raises hold requests just after a rising ref_clk edge.
`timescale 1ns/100ps
module sys_ctrl_model (
    input wire logic ref_clk,
    input wire logic hold_req,
    input wire logic dev_init_out,
    input wire logic dev_init_oe,
    output logic init_wire
);
    logic hold_low_reg = 1'b0;
    ////////////////////////////////////////////////////////////////////////////////
    // The hold follows the request one cycle later, changing just after the edge.
    always @(posedge ref_clk) begin
        hold_low_reg <= #2 hold_req;
    end
    // Open-drain line with an external pull-up, so a released line reads high.
    assign init_wire = (hold_low_reg || (dev_init_oe && !dev_init_out)) ? 1'b0 : 1'b1;
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the configuration status pin logic.
// Assumes the sequencer package and a 25 MHz clock; the master wait is cut to 5 cycles.
`timescale 1ns/100ps
module tb_top;
    localparam int WAITC = 5;
    typedef struct packed {
        logic [7:0] gi, gl, gs, gu, ls, gio;
        logic [3:0] si, sl, ss, su, sn, sio, fi;
    } row_s;
    row_s rows [3] = '{
        '{8'hf0, 8'h3c, 8'h00, 8'hff, 8'hf0, 8'h00, 4'ha, 4'h5, 4'h0, 4'hf, 4'ha, 4'h0, 4'ha},
        '{8'hf0, 8'h3c, 8'hff, 8'h00, 8'h3c, 8'hf0, 4'ha, 4'h5, 4'hf, 4'h0, 4'h5, 4'ha, 4'h5},
        '{8'hc3, 8'h55, 8'h0f, 8'hf0, 8'hc5, 8'h03, 4'h6, 4'h9, 4'h3, 4'h4, 4'h5, 4'h2, 4'h3}};
    logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, power_stable = 1'b0, master_mode = 1'b0;
    logic load_done = 1'b0, data_error = 1'b0, boundary_scan_macro = 1'b0, init_in, hold_req = 1'b0;
    logic init_out, init_oe, config_busy_high_out, config_busy_high_oe, config_busy_low_out;
    logic config_busy_low_oe, config_start, user_io_active, scan_enable;
    logic user_init_out = 1'b1, user_init_oe = 1'b1, user_busy_high_out = 1'b0;
    logic user_busy_high_oe = 1'b0, user_busy_low_out = 1'b1, user_busy_low_oe = 1'b1;
    logic [2:0] test_pads_in = 3'h5, test_to_scan, test_to_user;
    logic [7:0] global_clock_inputs = 8'h00, global_from_logic = 8'h00, global_sel_logic = 8'h00;
    logic [7:0] global_pin_used = 8'h00, low_skew_clock_buffer, early_clock_buffer, global_user_io;
    logic [3:0] secondary_global_inputs = 4'h0, secondary_from_logic = 4'h0;
    logic [3:0] secondary_sel_logic = 4'h0, secondary_pin_used = 4'h0, secondary_global_net;
    logic [3:0] secondary_user_io, fast_io_clock_inputs = 4'h0, fast_octant_clock;
    int n_fail = 0, checks_done = 0, n, seen;
    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 40 ns period.
    always #20 ref_clk = ~ref_clk;
    config_status_pin_logic #(.WAIT_CYCLES(WAITC)) config_status_pin_logic_inst (.ref_clk, .rst,
        .clk_en, .power_stable, .master_mode, .load_done, .data_error, .boundary_scan_macro,
        .init_in, .init_out, .init_oe, .config_busy_high_out, .config_busy_high_oe,
        .config_busy_low_out, .config_busy_low_oe, .config_start, .user_io_active,
        .user_init_out, .user_init_oe, .user_busy_high_out, .user_busy_high_oe,
        .user_busy_low_out, .user_busy_low_oe, .test_pads_in, .test_to_scan, .test_to_user,
        .scan_enable, .global_clock_inputs, .global_from_logic, .global_sel_logic,
        .global_pin_used, .low_skew_clock_buffer, .early_clock_buffer, .global_user_io,
        .secondary_global_inputs, .secondary_from_logic, .secondary_sel_logic,
        .secondary_pin_used, .secondary_global_net, .secondary_user_io, .fast_io_clock_inputs,
        .fast_octant_clock);
    sys_ctrl_model sys_ctrl_model_inst (.ref_clk(ref_clk), .hold_req(hold_req),
        .dev_init_out(init_out), .dev_init_oe(init_oe), .init_wire(init_in));
    ////////////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Compares a seen value with the expected one and counts the result.
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Advances whole cycles and lands just after the edge.
    task automatic step(input int k);
        repeat (k) @(posedge ref_clk);
        #2;
    endtask
    // Waits a bounded time: 0 for the start pulse, 1 for user mode, 2 for init released.
    task automatic wait_for(input int sel, output int cyc);
        logic hit;
        for (cyc = 1; cyc <= 200; cyc++) begin
            step(1);
            hit = (sel == 0) ? config_start : (sel == 1) ? user_io_active : !init_oe;
            if (hit === 1'b1) return;
        end
        n_fail++;
        $display("MISMATCH wait %0d expected event seen timeout", sel);
        stop_test();
    endtask
    // Holds reset for six cycles, checks the pin levels, then sets the supply flag to pwr.
    task automatic do_reset(input logic pwr);
        rst = 1'b1;
        power_stable = 1'b0;
        load_done = 1'b0;
        data_error = 1'b0;
        step(6);
        check("rst_init_oe", init_oe, 1'b1);
        check("rst_init_out", init_out, 1'b0);
        check("rst_bh", {config_busy_high_oe, config_busy_high_out}, 2'h3);
        check("rst_bl", {config_busy_low_oe, config_busy_low_out}, 2'h2);
        check("rst_scan", scan_enable, 1'b1);
        rst = 1'b0;
        power_stable = pwr;
    endtask
    // Runs one configuration to the start pulse and returns the cycles after init release.
    task automatic to_start(output int cyc);
        do_reset(1'b1);
        step(3);
        check("clear_init_oe", init_oe, 1'b1);
        wait_for(2, n);
        wait_for(0, cyc);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: held slave start, routing table, master wait, data error.
    initial begin
        hold_req = 1'b1;
        do_reset(1'b1);
        wait_for(2, n);
        seen = 0;
        repeat (20) begin
            step(1);
            if (config_start !== 1'b0) seen++;
        end
        check("held_start", seen, 0);
        hold_req = 1'b0;
        wait_for(0, n);
        check("load_bh", {user_io_active, config_busy_high_oe, config_busy_high_out}, 3'h3);
        check("load_bl", {config_busy_low_oe, config_busy_low_out}, 2'h2);
        load_done = 1'b1;
        wait_for(1, n);
        load_done = 1'b0;
        step(2);
        check("user_bh", {config_busy_high_oe, config_busy_high_out}, 2'h0);
        check("user_bl", {config_busy_low_oe, config_busy_low_out}, 2'h3);
        check("user_init", {init_oe, init_out}, 2'h3);
        check("user_scan", {scan_enable, test_to_scan}, 4'h0);
        check("user_test", test_to_user, 3'h5);
        foreach (rows[i]) begin
            {global_clock_inputs, global_from_logic, global_sel_logic} = {rows[i].gi,
                rows[i].gl, rows[i].gs};
            global_pin_used = rows[i].gu;
            {secondary_global_inputs, secondary_from_logic} = {rows[i].si, rows[i].sl};
            {secondary_sel_logic, secondary_pin_used} = {rows[i].ss, rows[i].su};
            fast_io_clock_inputs = rows[i].fi;
            step(5);
            check("low_skew", low_skew_clock_buffer, rows[i].ls);
            check("early", early_clock_buffer, rows[i].ls);
            check("global_io", global_user_io, rows[i].gio);
            check("sec_net", secondary_global_net, rows[i].sn);
            check("sec_io", secondary_user_io, rows[i].sio);
            check("fast", fast_octant_clock, rows[i].fi);
        end
        // A low clock enable freezes the synchronisers and the routing registers.
        clk_en = 1'b0;
        fast_io_clock_inputs = 4'h9;
        step(5);
        check("frozen", fast_octant_clock, rows[2].fi);
        clk_en = 1'b1;
        step(5);
        check("thawed", fast_octant_clock, 4'h9);
        master_mode = 1'b1;
        boundary_scan_macro = 1'b1;
        test_pads_in = 3'h6;
        to_start(n);
        check("master_min", n >= WAITC, 1'b1);
        check("master_max", n <= WAITC + 6, 1'b1);
        check("load_test", {scan_enable, test_to_scan, test_to_user}, 7'h70);
        load_done = 1'b1;
        wait_for(1, n);
        load_done = 1'b0;
        step(2);
        check("macro_scan", {scan_enable, test_to_scan}, 4'he);
        master_mode = 1'b0;
        boundary_scan_macro = 1'b0;
        to_start(n);
        data_error = 1'b1;
        step(3);
        data_error = 1'b0;
        load_done = 1'b1;
        step(10);
        check("err_init", {init_oe, init_out}, 2'h2);
        check("err_user", user_io_active, 1'b0);
        // An unsettled supply keeps the sequencer at power-up with init held low.
        do_reset(1'b0);
        step(30);
        check("power_hold", {init_oe, init_out, config_busy_high_out}, 3'h5);
        check("power_user", {user_io_active, config_start}, 2'h0);
        stop_test();
    end
    // Cuts a hang short.
    initial begin
        #400000;
        n_fail++;
        stop_test();
    end
endmodule
